// [verilog/fmrp_defines.svh]
// Register offsets, field positions and reset values of the frame memory read pointer port.
// Assumes inclusion by bare name from the port module.
`ifndef FMRP_DEFINES_SVH
`define FMRP_DEFINES_SVH

`define FMRP_REG_DATA_PORT    8'h48
`define FMRP_REG_PTR_LOW      8'h4A
`define FMRP_REG_PTR_MID      8'h4C
`define FMRP_REG_PTR_HIGH     8'h4E
`define FMRP_REG_STEP         8'h02
`define FMRP_IDX_RESET        8'h00
`define FMRP_PTR_RESET        20'h00000
`define FMRP_LOW_MSB          7
`define FMRP_MID_MSB          15
`define FMRP_HIGH_MSB         19
`define FMRP_HIGH_NIBBLE_MSB  3

`endif

// [verilog/fmrp_pkg.sv]
// Types shared by the frame memory read pointer port.
// Assumes the host strobes come from logic on the same clock.
`default_nettype none

package fmrp_pkg;

	typedef struct packed {
		logic        idx_wr;
		logic        dat_wr;
		logic        dat_rd;
		logic [15:0] din;
	} fmrp_host_req_t;

	typedef struct packed {
		logic        rd_req;
		logic        wr_req;
		logic [19:0] addr;
		logic [15:0] wdata;
	} fmrp_mem_req_t;

	typedef enum logic {
		FMRP_IDLE,
		FMRP_WAIT_MEM
	} fmrp_state_t;

endpackage

`default_nettype wire

// [verilog/fmrp_port.sv]
// Host access to the frame memory: indexed register file, read pointer and window write pointer.
// Assumes the host holds off new strobes while busy and that memory answers each read once.
//
// Operation
// - After the window's last pixel, write pointer returns to the first pixel.
// - The 20-bit pointer serves single-location reads only, never writes.
// - Read pointer increments itself after each completed memory read.
// - Pointer bits come from low, middle and high-nibble byte registers.
// - All pixel writes go through the data port at window coordinates.
// - In 16-bit bus mode address bit 0 is ignored, word fetches.
// - In 8-bit bus mode address bit 0 is used, byte fetches.
`timescale 1ns/100ps
`default_nettype none
`include "fmrp_defines.svh"

module fmrp_port (
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic                    bus16,
	input  wire fmrp_pkg::fmrp_host_req_t host_req,
	input  wire logic [19:0]             win_first,
	input  wire logic [19:0]             win_last,
	input  wire logic                    win_load,
	input  wire logic                    mem_rd_ack,
	input  wire logic [15:0]             mem_rdata,
	output var fmrp_pkg::fmrp_mem_req_t   mem_req,
	output logic [15:0]                  host_dout,
	output logic                         host_dvalid,
	output logic                         busy
);

	fmrp_pkg::fmrp_state_t   state_q, state_d;
	fmrp_pkg::fmrp_mem_req_t mem_q, mem_d;
	logic [7:0]              idx_q, idx_d;
	logic [19:0]             rptr_q, rptr_d;
	logic [19:0]             wptr_q, wptr_d;
	logic [15:0]             dout_q, dout_d;
	logic                    dvalid_q, dvalid_d;
	logic                    busy_q, busy_d;
	logic [19:0]             step;
	logic [19:0]             rd_addr;

	assign step    = bus16 ? 20'h00002 : 20'h00001;
	assign rd_addr = bus16 ? {rptr_q[19:1], 1'b0} : rptr_q;

	always_comb begin
		state_d      = state_q;
		mem_d        = mem_q;
		idx_d        = idx_q;
		rptr_d       = rptr_q;
		wptr_d       = wptr_q;
		dout_d       = dout_q;
		dvalid_d     = 1'b0;
		mem_d.rd_req = 1'b0;
		mem_d.wr_req = 1'b0;
		if (win_load) begin
			wptr_d = win_first;
		end
		unique case (state_q)
			fmrp_pkg::FMRP_IDLE: begin
				// Host strobes are taken only while no fetch is outstanding
				if (host_req.idx_wr) begin
					idx_d = host_req.din[7:0];
				end else if (host_req.dat_wr) begin
					// Pointer byte writes step the index so three writes load the pointer
					unique case (idx_q)
						`FMRP_REG_PTR_LOW: begin
							rptr_d[`FMRP_LOW_MSB:0] = host_req.din[7:0];
							idx_d = idx_q + `FMRP_REG_STEP;
						end
						`FMRP_REG_PTR_MID: begin
							rptr_d[`FMRP_MID_MSB:`FMRP_LOW_MSB+1] = host_req.din[7:0];
							idx_d = idx_q + `FMRP_REG_STEP;
						end
						`FMRP_REG_PTR_HIGH: begin
							rptr_d[`FMRP_HIGH_MSB:`FMRP_MID_MSB+1] = host_req.din[`FMRP_HIGH_NIBBLE_MSB:0];
							idx_d = idx_q + `FMRP_REG_STEP;
						end
						`FMRP_REG_DATA_PORT: begin
							// Pixel writes use the window pointer only
							mem_d.wr_req = 1'b1;
							mem_d.addr   = wptr_q;
							mem_d.wdata  = host_req.din;
							if (wptr_q >= win_last) begin
								wptr_d = win_first;
							end else begin
								wptr_d = wptr_q + step;
							end
						end
						default: begin
						end
					endcase
				end else if (host_req.dat_rd) begin
					unique case (idx_q)
						`FMRP_REG_PTR_LOW: begin
							dout_d   = {8'h00, rptr_q[`FMRP_LOW_MSB:0]};
							dvalid_d = 1'b1;
						end
						`FMRP_REG_PTR_MID: begin
							dout_d   = {8'h00, rptr_q[`FMRP_MID_MSB:`FMRP_LOW_MSB+1]};
							dvalid_d = 1'b1;
						end
						`FMRP_REG_PTR_HIGH: begin
							dout_d   = {12'h000, rptr_q[`FMRP_HIGH_MSB:`FMRP_MID_MSB+1]};
							dvalid_d = 1'b1;
						end
						`FMRP_REG_DATA_PORT: begin
							// Index stays put so the data port can be read again
							mem_d.rd_req = 1'b1;
							mem_d.addr   = rd_addr;
							state_d      = fmrp_pkg::FMRP_WAIT_MEM;
						end
						default: begin
							dout_d   = 16'h0000;
							dvalid_d = 1'b1;
						end
					endcase
				end
			end
			fmrp_pkg::FMRP_WAIT_MEM: begin
				if (mem_rd_ack) begin
					dout_d   = mem_rdata;
					dvalid_d = 1'b1;
					rptr_d   = rd_addr + step;
					state_d  = fmrp_pkg::FMRP_IDLE;
				end
			end
		endcase
		busy_d = (state_d == fmrp_pkg::FMRP_WAIT_MEM);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q  <= fmrp_pkg::FMRP_IDLE;
			mem_q    <= '0;
			idx_q    <= `FMRP_IDX_RESET;
			rptr_q   <= `FMRP_PTR_RESET;
			wptr_q   <= `FMRP_PTR_RESET;
			dout_q   <= 16'h0000;
			dvalid_q <= 1'b0;
			busy_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			mem_q    <= mem_d;
			idx_q    <= idx_d;
			rptr_q   <= rptr_d;
			wptr_q   <= wptr_d;
			dout_q   <= dout_d;
			dvalid_q <= dvalid_d;
			busy_q   <= busy_d;
		end
	end

	assign mem_req     = mem_q;
	assign host_dout   = dout_q;
	assign host_dvalid = dvalid_q;
	// Busy comes from its own flop so the host sees a clean level
	assign busy        = busy_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_last_pixel;
		(state_q == fmrp_pkg::FMRP_IDLE) && host_req.dat_wr && !host_req.idx_wr
			&& (idx_q == `FMRP_REG_DATA_PORT) && (wptr_q >= win_last) && !win_load;
	endsequence

	a_window_wrap_first: assert property (s_last_pixel |=> wptr_q == $past(win_first))
		else $error("Write pointer did not return to window start");

	a_write_uses_window: assert property (mem_q.wr_req |-> mem_q.addr == $past(wptr_q))
		else $error("Memory write not at window pointer");

	a_no_ptr_write: assert property (mem_q.wr_req |-> !mem_q.rd_req && !busy)
		else $error("Read pointer path used for a write");

	a_ptr_inc_ack: assert property (busy && mem_rd_ack |=> !busy && host_dvalid
		&& rptr_q == $past(rd_addr) + $past(step))
		else $error("Read pointer not advanced after access");

	a_high_nibble_load: assert property ((state_q == fmrp_pkg::FMRP_IDLE) && host_req.dat_wr && !host_req.idx_wr
		&& idx_q == `FMRP_REG_PTR_HIGH |=> rptr_q[19:16] == $past(host_req.din[3:0])
		&& idx_q == $past(idx_q) + `FMRP_REG_STEP)
		else $error("High pointer nibble not loaded");

	a_word_fetch_align: assert property (mem_q.rd_req && bus16 |-> mem_q.addr[0] == 1'b0)
		else $error("Word fetch not aligned");

	a_byte_fetch_addr: assert property (mem_q.rd_req && !bus16 && $stable(bus16) |-> mem_q.addr == rptr_q)
		else $error("Byte fetch address wrong");

	sequence s_data_port_read;
		(state_q == fmrp_pkg::FMRP_IDLE) && host_req.dat_rd && !host_req.dat_wr && !host_req.idx_wr
			&& (idx_q == `FMRP_REG_DATA_PORT);
	endsequence

	a_read_issues_fetch: assert property (s_data_port_read |=> mem_q.rd_req && busy
		&& mem_q.addr == $past(rd_addr))
		else $error("Data port read did not start a fetch");

	a_fetch_single_pulse: assert property (mem_q.rd_req |=> !mem_q.rd_req)
		else $error("Fetch request longer than one cycle");

	sequence s_reg_read;
		(state_q == fmrp_pkg::FMRP_IDLE) && host_req.dat_rd && !host_req.dat_wr && !host_req.idx_wr
			&& (idx_q != `FMRP_REG_DATA_PORT);
	endsequence

	a_reg_read_answer: assert property (s_reg_read |=> host_dvalid && !busy && !mem_q.rd_req
		&& host_dout[15:8] == 8'h00)
		else $error("Register read not answered");

	a_low_byte_load: assert property ((state_q == fmrp_pkg::FMRP_IDLE) && host_req.dat_wr && !host_req.idx_wr
		&& idx_q == `FMRP_REG_PTR_LOW |=> rptr_q[7:0] == $past(host_req.din[7:0])
		&& rptr_q[19:8] == $past(rptr_q[19:8]))
		else $error("Low pointer byte not loaded");

	a_mid_byte_load: assert property ((state_q == fmrp_pkg::FMRP_IDLE) && host_req.dat_wr && !host_req.idx_wr
		&& idx_q == `FMRP_REG_PTR_MID |=> rptr_q[15:8] == $past(host_req.din[7:0])
		&& rptr_q[7:0] == $past(rptr_q[7:0]))
		else $error("Middle pointer byte not loaded");

endmodule // fmrp_port

`default_nettype wire

// [tb/fmrp_mem_model.sv]
// Frame memory stand-in: answers each read after LAT cycles.
// Assumes one read outstanding at a time; writes are not stored.
`timescale 1ns/100ps
`default_nettype none
module fmrp_mem_model #(
	parameter int LAT = 3
) (
	input  wire logic                    ref_clk,
	input  wire fmrp_pkg::fmrp_mem_req_t mem_req,
	output logic                         mem_rd_ack,
	output logic [15:0]                  mem_rdata
);
	int          cnt = 0;
	logic [19:0] a;
	initial begin
		mem_rd_ack = 1'b0;
		mem_rdata  = 16'h0000;
	end
	// Data is an address pattern; it toggles when not valid
	always @(posedge ref_clk) begin
		mem_rd_ack <= 1'b0;
		mem_rdata  <= ~mem_rdata;
		if (mem_req.rd_req === 1'b1) begin
			a = mem_req.addr;
			cnt = LAT;
		end else if (cnt > 0) begin
			cnt = cnt - 1;
			if (cnt == 0) begin
				mem_rd_ack <= 1'b1;
				mem_rdata  <= a[15:0] ^ 16'h5A5A;
			end
		end
	end
endmodule // fmrp_mem_model
`default_nettype wire

// [tb/frame_memory_read_pointer_port_test.sv]
// Bench for the read pointer port: register accesses, reads, window writes.
// Assumes the memory model answers reads with address ^ 5A5Ah.
`timescale 1ns/100ps
`default_nettype none
module frame_memory_read_pointer_port_test;
	logic                     ref_clk = 1'b0;
	logic                     nrst, bus16, win_load, ack;
	logic [19:0]              wf, wl, ra, wa;
	logic [15:0]              rdat, dout, wd;
	logic                     dv, busy;
	fmrp_pkg::fmrp_host_req_t hr;
	fmrp_pkg::fmrp_mem_req_t  mr;
	int                       n_fail = 0, n_checks = 0, cyc = 0;

	fmrp_port u_dut (.ref_clk(ref_clk), .nrst(nrst), .bus16(bus16), .host_req(hr), .win_first(wf),
		.win_last(wl), .win_load(win_load), .mem_rd_ack(ack), .mem_rdata(rdat), .mem_req(mr),
		.host_dout(dout), .host_dvalid(dv), .busy(busy));
	fmrp_mem_model u_mem (.ref_clk(ref_clk), .mem_req(mr), .mem_rd_ack(ack), .mem_rdata(rdat));

	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (mr.rd_req === 1'b1) ra <= mr.addr;
		if (mr.wr_req === 1'b1) wa <= mr.addr;
		if (mr.wr_req === 1'b1) wd <= mr.wdata;
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			stop_test();
		end
	end

	task automatic stop_test;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic strobe(input logic i, input logic w, input logic r, input logic [15:0] d);
		@(posedge ref_clk) #1;
		hr = '{idx_wr: i, dat_wr: w, dat_rd: r, din: d};
		@(posedge ref_clk) #1;
		hr = '0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [15:0] e);
		strobe(1'b1, 1'b0, 1'b0, {8'h00, i});
		strobe(1'b0, 1'b0, 1'b1, 16'h0000);
		chk({19'h00000, busy}, {19'h00000, i == 8'h48});
		for (int k = 0; k < 20 && dv !== 1'b1; k++) @(posedge ref_clk) #1;
		chk({19'h00000, dv}, 20'h00001);
		chk({4'h0, dout}, {4'h0, e});
	endtask
	task automatic load(input logic [19:0] p);
		strobe(1'b1, 1'b0, 1'b0, 16'h004A);
		strobe(1'b0, 1'b1, 1'b0, {8'h00, p[7:0]});
		strobe(1'b0, 1'b1, 1'b0, {8'h00, p[15:8]});
		strobe(1'b0, 1'b1, 1'b0, {12'h000, p[19:16]});
	endtask
	task automatic wpix(input logic [19:0] e);
		strobe(1'b0, 1'b1, 1'b0, 16'hBEEF);
		@(posedge ref_clk) #1;
		chk(wa, e);
		chk({4'h0, wd}, 20'h0BEEF);
	endtask

	initial begin
		nrst = 1'b0;
		hr = '0;
		bus16 = 1'b0;
		win_load = 1'b0;
		wf = 20'h00100;
		wl = 20'h00102;
		repeat (6) @(posedge ref_clk);
		#1 nrst = 1'b1;
		load(20'h12345);
		rd(8'h4A, 16'h0045);
		rd(8'h4C, 16'h0023);
		rd(8'h4E, 16'h0001);
		rd(8'h48, 16'h791F);
		chk(ra, 20'h12345);
		rd(8'h48, 16'h791C);
		chk(ra, 20'h12346);
		bus16 = 1'b1;
		load(20'h0ABC3);
		rd(8'h48, 16'hF198);
		chk(ra, 20'h0ABC2);
		@(posedge ref_clk) #1;
		win_load = 1'b1;
		@(posedge ref_clk) #1;
		win_load = 1'b0;
		strobe(1'b1, 1'b0, 1'b0, 16'h0048);
		wpix(20'h00100);
		wpix(20'h00102);
		wpix(20'h00100);
		rd(8'h48, 16'hF19E);
		chk(ra, 20'h0ABC4);
		@(posedge ref_clk) #1;
		nrst = 1'b0;
		@(posedge ref_clk) #1;
		nrst = 1'b1;
		rd(8'h4C, 16'h0000);
		stop_test();
	end
endmodule // frame_memory_read_pointer_port_test
`default_nettype wire
